// >>> inc/afm_pkg.sv
package afm_pkg;
    localparam int N_STAGE = 8;
    localparam int N_SENS = 10;
    localparam int N_VOUT = 6;
    localparam int N_TRIP = 4;
    localparam int N_OUT = 5;
    localparam int N_EVT = 12;
    localparam int N_PIN = 34;
    localparam int LSEL_W = N_SENS + 1 + N_VOUT + N_STAGE;
    localparam int CSEL_W = 3 + N_VOUT + N_STAGE;

    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int MSW = $clog2(MS_CYCLES);
    localparam int HOLD_UNIT_MS = 10;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_PHASE_THR = 8'h08;
    localparam logic [7:0] ADR_RESID_THR = 8'h0C;
    localparam logic [7:0] ADR_TRIP_MAP = 8'h10;
    localparam logic [7:0] ADR_ALARM_MAP = 8'h14;
    localparam logic [7:0] ADR_EVT_EN = 8'h18;
    localparam logic [7:0] ADR_INSTALLED = 8'h1C;
    localparam logic [7:0] ADR_LSEL = 8'h20;
    localparam logic [7:0] ADR_CSEL = 8'h40;
    localparam logic [7:0] ADR_TIMING = 8'h60;

    localparam int CTRL_CLR_BIT = 8;
    localparam int CTRL_INSTALL_BIT = 9;
    localparam int ST_OUT_LSB = 8;
    localparam int ST_READY_BIT = 16;
    localparam int ST_CARD_BIT = 17;
    localparam int ALARM_LATCH_LSB = 8;
    localparam int TIMING_HOLD_LSB = 8;
    localparam int EVT_OFF_LSB = 16;

    localparam logic [9:0] PHASE_THR_MIN = 10'h032;
    localparam logic [9:0] PHASE_THR_MAX = 10'h320;
    localparam logic [9:0] RESID_THR_MIN = 10'h00A;
    localparam logic [9:0] RESID_THR_MAX = 10'h1F4;
    localparam logic [9:0] THR_RST = 10'h064;
    localparam logic [7:0] HOLD_MIN = 8'h02;
    localparam logic [7:0] HOLD_RST = 8'h02;
    localparam logic [7:0] DELAY_RST = 8'h00;
    localparam logic [7:0] STAGE_EN_RST = 8'h00;
    localparam logic [11:0] EVT_EN_RST = 12'hFFF;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_DELAY = 2'b01, ST_HOLD = 2'b10} afm_stage_e;
    typedef enum logic {INST_READY = 1'b0, INST_BUSY = 1'b1} afm_inst_e;
endpackage

// >>> inc/afm_stage_if.sv
`timescale 1ns/100ps
`default_nettype none
interface afm_stage_if;
    logic enable;
    logic cond;
    logic ms_tick;
    logic tick_10ms;
    logic [7:0] delay;
    logic [7:0] hold;
    logic active;
    modport stage(input enable, input cond, input ms_tick, input tick_10ms, input delay, input hold,
        output active);
    modport ctrl(output enable, output cond, output ms_tick, output tick_10ms, output delay, output hold,
        input active);
endinterface
`default_nettype wire

// >>> rtl/afm_stage.sv
`timescale 1ns/100ps
`default_nettype none
module afm_stage
    import afm_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    afm_stage_if.stage sif
);
    typedef struct packed {
        afm_stage_e st;
        logic [8:0] cnt;
    } afm_stg_s;

    afm_stg_s s_r;
    afm_stg_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            ST_IDLE: begin
                if (sif.cond) begin
                    if (sif.delay == DELAY_RST) begin
                        s_nxt.st = ST_HOLD;
                        s_nxt.cnt = {1'b0, sif.hold} + 9'h001;
                    end else begin
                        s_nxt.st = ST_DELAY;
                        s_nxt.cnt = {1'b0, sif.delay};
                    end
                end
            end
            ST_DELAY: begin
                if (!sif.cond) begin
                    s_nxt.st = ST_IDLE;
                end else if (sif.ms_tick) begin
                    if (s_r.cnt == 9'h001) begin
                        s_nxt.st = ST_HOLD;
                        s_nxt.cnt = {1'b0, sif.hold} + 9'h001;
                    end else begin
                        s_nxt.cnt = s_r.cnt - 9'h001;
                    end
                end
            end
            ST_HOLD: begin
                if (sif.tick_10ms && s_r.cnt != 9'h000) begin
                    s_nxt.cnt = s_r.cnt - 9'h001;
                end
                if (!sif.cond && s_r.cnt == 9'h000) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        if (!sif.enable) begin
            s_nxt.st = ST_IDLE;
            s_nxt.cnt = 9'h000;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '{st: ST_IDLE, cnt: 9'h000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.active = (s_r.st == ST_HOLD);
endmodule // afm_stage
`default_nettype wire

// >>> rtl/afm_top.sv
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module afm_top
    import afm_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [N_SENS-1:0] light_sensor,
    input wire logic network_arc_input,
    input wire logic phase_oc,
    input wire logic resid_oc,
    input wire logic [N_VOUT-1:0] virtual_out,
    input wire logic card_present,
    input wire logic [N_SENS-1:0] sensor_present,
    input wire logic [N_SENS-1:0] sensor_link_ok,
    output logic [N_TRIP-1:0] trip_outputs,
    output logic alarm_relay_output,
    output logic [9:0] phase_threshold,
    output logic [9:0] resid_threshold,
    output logic [39:0] general_matrix_set,
    output logic [N_STAGE-1:0] stage_active,
    output logic event_valid,
    output logic [4:0] event_code,
    output logic install_ready
);
    typedef struct packed {
        logic [N_PIN-1:0] sy1;
        logic [N_PIN-1:0] sy2;
        logic [N_STAGE-1:0] stage_en;
        logic [N_STAGE-1:0][LSEL_W-1:0] lsel;
        logic [N_STAGE-1:0][CSEL_W-1:0] csel;
        logic [N_TRIP-1:0][7:0] trip_map;
        logic [7:0] alarm_map;
        logic [N_OUT-1:0] latch_en;
        logic [N_STAGE-1:0][7:0] delay;
        logic [N_STAGE-1:0][7:0] hold;
        logic [N_EVT-1:0] evt_on_en;
        logic [N_EVT-1:0] evt_off_en;
        logic [9:0] phase_thr;
        logic [9:0] resid_thr;
        logic [N_OUT-1:0] latched;
        logic [N_OUT-1:0] outs;
        afm_inst_e inst;
        logic [N_SENS-1:0] installed;
        logic [N_EVT-1:0] ev_prev;
        logic [N_EVT-1:0] pend_on;
        logic [N_EVT-1:0] pend_off;
        logic ev_valid;
        logic [4:0] ev_code;
        logic ack;
        logic [31:0] dat;
        logic [MSW-1:0] ms_cnt;
        logic ms_tick;
        logic [3:0] ten_cnt;
        logic tick10;
        logic clr_cmd;
        logic inst_cmd;
    } afm_top_s;

    afm_top_s s_r;
    afm_top_s s_nxt;

    logic [N_STAGE-1:0] act;
    logic [N_SENS-1:0] light_s;
    logic net_s;
    logic phase_s;
    logic resid_s;
    logic card_s;
    logic [N_SENS-1:0] present_s;
    logic [N_SENS-1:0] link_s;
    logic [LSEL_W-1:0] light_vec;
    logic [CSEL_W-1:0] cur_vec;
    logic [N_STAGE-1:0] cond;
    logic [N_OUT-1:0] raw;
    logic [N_EVT-1:0] ev_src;

    assign light_s = s_r.sy2[9:0];
    assign net_s = s_r.sy2[10];
    assign phase_s = s_r.sy2[11];
    assign resid_s = s_r.sy2[12];
    assign card_s = s_r.sy2[13];
    assign present_s = s_r.sy2[23:14];
    assign link_s = s_r.sy2[33:24];

    assign light_vec = {act, virtual_out, net_s, light_s};
    assign cur_vec = {act, virtual_out, net_s, resid_s, phase_s};
    assign ev_src = {act, light_s[1:0], resid_s, phase_s};

    afm_stage_if sif [N_STAGE] ();

    for (genvar g = 0; g < N_STAGE; g++) begin : g_stage
        logic l_any;
        logic c_any;
        logic l_used;
        logic c_used;
        assign l_any = |(s_r.lsel[g] & light_vec);
        assign c_any = |(s_r.csel[g] & cur_vec);
        assign l_used = |s_r.lsel[g];
        assign c_used = |s_r.csel[g];
        assign cond[g] = (l_used | c_used) & (~l_used | l_any) & (~c_used | c_any);
        assign sif[g].enable = s_r.stage_en[g];
        assign sif[g].cond = cond[g];
        assign sif[g].ms_tick = s_r.ms_tick;
        assign sif[g].tick_10ms = s_r.tick10;
        assign sif[g].delay = s_r.delay[g];
        assign sif[g].hold = s_r.hold[g];
        assign act[g] = sif[g].active;
        afm_stage u_stage (
            .mclk(mclk),
            .arst_n(arst_n),
            .sif(sif[g])
        );
    end

    for (genvar o = 0; o < N_TRIP; o++) begin : g_trip
        assign raw[o] = |(s_r.trip_map[o] & act);
    end
    assign raw[N_TRIP] = |(s_r.alarm_map & act);

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic req;
        logic [2:0] idx;
        logic [31:0] cur;
        logic [31:0] wv;
        logic [N_EVT-1:0] on_clr;
        logic [N_EVT-1:0] off_clr;
        req = 1'b0;
        idx = wb_adr_i[4:2];
        cur = 32'h0000_0000;
        wv = 32'h0000_0000;
        on_clr = '0;
        off_clr = '0;
        s_nxt = s_r;
        s_nxt.sy1 = {sensor_link_ok, sensor_present, card_present, resid_oc, phase_oc, network_arc_input,
            light_sensor};
        s_nxt.sy2 = s_r.sy1;

        // timebase: 1 ms and 10 ms enables
        s_nxt.ms_tick = 1'b0;
        s_nxt.tick10 = 1'b0;
        if (s_r.ms_cnt == MSW'(MS_CYC - 1)) begin
            s_nxt.ms_cnt = '0;
            s_nxt.ms_tick = 1'b1;
        end else begin
            s_nxt.ms_cnt = s_r.ms_cnt + MSW'(1);
        end
        if (s_r.ms_tick) begin
            if (s_r.ten_cnt == 4'(HOLD_UNIT_MS - 1)) begin
                s_nxt.ten_cnt = 4'h0;
                s_nxt.tick10 = 1'b1;
            end else begin
                s_nxt.ten_cnt = s_r.ten_cnt + 4'h1;
            end
        end

        s_nxt.latched = (s_r.latched & ~{N_OUT{s_r.clr_cmd}}) | (raw & s_r.latch_en);
        s_nxt.outs = raw | s_r.latched;

        unique case (s_r.inst)
            INST_READY: if (s_r.inst_cmd) s_nxt.inst = INST_BUSY;
            INST_BUSY: begin
                if ((present_s & ~link_s) == '0) begin
                    s_nxt.inst = INST_READY;
                    s_nxt.installed = present_s;
                end
            end
        endcase

        // events: one per cycle, lowest index first, on before off
        s_nxt.ev_prev = ev_src;
        s_nxt.ev_valid = 1'b0;
        s_nxt.ev_code = s_r.ev_code;
        for (int i = N_EVT - 1; i >= 0; i--) begin
            if (s_r.pend_off[i] || s_r.pend_on[i]) begin
                s_nxt.ev_valid = 1'b1;
                s_nxt.ev_code = {~s_r.pend_on[i], 4'(i)};
                on_clr = '0;
                off_clr = '0;
                if (s_r.pend_on[i]) on_clr[i] = 1'b1;
                else off_clr[i] = 1'b1;
            end
        end
        s_nxt.pend_on = (s_r.pend_on & ~on_clr) | (ev_src & ~s_r.ev_prev & s_r.evt_on_en);
        s_nxt.pend_off = (s_r.pend_off & ~off_clr) | (~ev_src & s_r.ev_prev & s_r.evt_off_en);

        // wishbone slave, one wait state
        s_nxt.ack = 1'b0;
        s_nxt.clr_cmd = 1'b0;
        s_nxt.inst_cmd = 1'b0;
        if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
            req = 1'b1;
        end
        if (wb_adr_i[7:5] == ADR_LSEL[7:5]) begin
            cur = 32'(s_r.lsel[idx]);
        end else if (wb_adr_i[7:5] == ADR_CSEL[7:5]) begin
            cur = 32'(s_r.csel[idx]);
        end else if (wb_adr_i[7:5] == ADR_TIMING[7:5]) begin
            cur = {16'h0000, s_r.hold[idx], s_r.delay[idx]};
        end else begin
            unique case ({wb_adr_i[7:2], 2'b00})
                ADR_CTRL: cur = {24'h0000_00, s_r.stage_en};
                ADR_STATUS: cur = {14'h0000, card_s, (s_r.inst == INST_READY), 3'h0, s_r.outs, act};
                ADR_PHASE_THR: cur = {22'h00_0000, s_r.phase_thr};
                ADR_RESID_THR: cur = {22'h00_0000, s_r.resid_thr};
                ADR_TRIP_MAP: cur = s_r.trip_map;
                ADR_ALARM_MAP: cur = {19'h0_0000, s_r.latch_en, s_r.alarm_map};
                ADR_EVT_EN: cur = {4'h0, s_r.evt_off_en, 4'h0, s_r.evt_on_en};
                ADR_INSTALLED: cur = {22'h00_0000, s_r.installed};
                default: cur = 32'h0000_0000;
            endcase
        end
        wv = wmerge(cur, wb_dat_i, wb_sel_i);
        if (req) begin
            s_nxt.ack = 1'b1;
            s_nxt.dat = wb_we_i ? 32'h0000_0000 : cur;
        end
        if (req && wb_we_i) begin
            if (wb_adr_i[7:5] == ADR_LSEL[7:5]) begin
                s_nxt.lsel[idx] = wv[LSEL_W-1:0];
            end else if (wb_adr_i[7:5] == ADR_CSEL[7:5]) begin
                s_nxt.csel[idx] = wv[CSEL_W-1:0];
            end else if (wb_adr_i[7:5] == ADR_TIMING[7:5]) begin
                s_nxt.delay[idx] = wv[7:0];
                s_nxt.hold[idx] = (wv[15:8] < HOLD_MIN) ? HOLD_MIN : wv[15:8];
            end else begin
                unique case ({wb_adr_i[7:2], 2'b00})
                    ADR_CTRL: begin
                        s_nxt.stage_en = wv[7:0];
                        s_nxt.clr_cmd = wb_sel_i[1] & wb_dat_i[CTRL_CLR_BIT];
                        s_nxt.inst_cmd = wb_sel_i[1] & wb_dat_i[CTRL_INSTALL_BIT];
                    end
                    ADR_PHASE_THR: begin
                        if (card_s && wv[9:0] >= PHASE_THR_MIN && wv[9:0] <= PHASE_THR_MAX) begin
                            s_nxt.phase_thr = wv[9:0];
                        end
                    end
                    ADR_RESID_THR: begin
                        if (card_s && wv[9:0] >= RESID_THR_MIN && wv[9:0] <= RESID_THR_MAX) begin
                            s_nxt.resid_thr = wv[9:0];
                        end
                    end
                    ADR_TRIP_MAP: s_nxt.trip_map = wv;
                    ADR_ALARM_MAP: begin
                        s_nxt.alarm_map = wv[7:0];
                        s_nxt.latch_en = wv[ALARM_LATCH_LSB +: N_OUT];
                    end
                    ADR_EVT_EN: begin
                        s_nxt.evt_on_en = wv[N_EVT-1:0];
                        s_nxt.evt_off_en = wv[EVT_OFF_LSB +: N_EVT];
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.stage_en <= STAGE_EN_RST;
            s_r.delay <= {N_STAGE{DELAY_RST}};
            s_r.hold <= {N_STAGE{HOLD_RST}};
            s_r.evt_on_en <= EVT_EN_RST;
            s_r.evt_off_en <= EVT_EN_RST;
            s_r.phase_thr <= THR_RST;
            s_r.resid_thr <= THR_RST;
            s_r.inst <= INST_READY;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.dat;
    assign trip_outputs = s_r.outs[N_TRIP-1:0];
    assign alarm_relay_output = s_r.outs[N_TRIP];
    assign phase_threshold = s_r.phase_thr;
    assign resid_threshold = s_r.resid_thr;
    assign general_matrix_set = {s_r.alarm_map, s_r.trip_map};
    assign stage_active = act;
    assign event_valid = s_r.ev_valid;
    assign event_code = s_r.ev_code;
    assign install_ready = (s_r.inst == INST_READY);
endmodule // afm_top
`default_nettype wire

// >>> sim/afm_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module afm_chk
    import afm_pkg::*;
#(
    parameter int MS_CYC = 10
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic card_present,
    input wire logic [N_TRIP-1:0] trip_outputs,
    input wire logic alarm_relay_output,
    input wire logic [9:0] phase_threshold,
    input wire logic [9:0] resid_threshold,
    input wire logic [39:0] general_matrix_set,
    input wire logic [N_STAGE-1:0] stage_active,
    input wire logic event_valid,
    input wire logic [4:0] event_code,
    input wire logic install_ready
);
    localparam int HOLD_CYC = int'(HOLD_MIN) * HOLD_UNIT_MS * MS_CYC;
    logic take;
    logic [31:0] hold_cnt_r;
    logic [31:0] hold_cnt_nxt;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // cycles stage 0 has been active without a break
    assign hold_cnt_nxt = stage_active[0] ? hold_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hold_cnt_r <= 32'h0000_0000;
        end else begin
            hold_cnt_r <= hold_cnt_nxt;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    AST_ACK_PULSE: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    AST_MAP_MIRROR: assert property (
        take && wb_we_i && wb_sel_i == 4'hF && wb_adr_i[7:2] == ADR_TRIP_MAP[7:2]
        |-> ##2 general_matrix_set[31:0] == $past(wb_dat_i, 2))
        else $error("trip map not mirrored");
    AST_TRIP_CAUSE: assert property (
        (trip_outputs & ~$past(trip_outputs)) != 4'h0 |-> $past(stage_active) != 8'h00)
        else $error("trip rose without active stage");
    AST_ALARM_CAUSE: assert property ($rose(alarm_relay_output) |-> $past(stage_active) != 8'h00)
        else $error("alarm rose without active stage");
    AST_HOLD_MIN: assert property ($fell(stage_active[0]) |-> hold_cnt_r >= HOLD_CYC)
        else $error("stage pulse shorter than minimum hold");
    AST_THR_CARD: assert property ($changed(phase_threshold) |-> $past(card_present, 3))
        else $error("threshold changed without card");
    AST_THR_BUS: assert property (
        $changed(phase_threshold) || $changed(resid_threshold) |-> wb_ack_o)
        else $error("threshold changed outside a write");
    AST_PH_RANGE: assert property (
        phase_threshold >= PHASE_THR_MIN && phase_threshold <= PHASE_THR_MAX)
        else $error("phase threshold out of range");
    AST_RS_RANGE: assert property (
        resid_threshold >= RESID_THR_MIN && resid_threshold <= RESID_THR_MAX)
        else $error("residual threshold out of range");
    AST_EVT_IDX: assert property (event_valid |-> event_code[3:0] < 4'hC)
        else $error("event index out of range");
    AST_INST_CAUSE: assert property ($fell(install_ready) |-> wb_ack_o || $past(wb_ack_o))
        else $error("install started without a write");
    cover property ($rose(trip_outputs[0]));
    cover property ($fell(install_ready));
    cover property (event_valid && event_code[4]);
endmodule // afm_chk
bind afm_top afm_chk #(.MS_CYC(MS_CYC)) chk_u (.*);
`default_nettype wire

// >>> sim/afm_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module afm_far_model
    import afm_pkg::*;
#(
    parameter logic [N_SENS-1:0] PRESENT = 10'h03C,
    parameter int LINK_DLY = 40
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [N_SENS-1:0] light_cmd,
    input wire logic install_ready,
    input wire logic [N_TRIP-1:0] trip_outputs,
    output logic [N_SENS-1:0] light_sensor,
    output logic [N_SENS-1:0] sensor_present,
    output logic [N_SENS-1:0] sensor_link_ok,
    output logic [N_TRIP-1:0] breaker_open
);
    int link_cnt;
    assign sensor_present = PRESENT;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            link_cnt <= 0;
            sensor_link_ok <= '0;
            light_sensor <= '0;
            breaker_open <= '0;
        end else begin
            light_sensor <= light_cmd;
            breaker_open <= breaker_open | trip_outputs;
            // links come up only after the relay starts installing
            if (!install_ready && link_cnt < LINK_DLY) begin
                link_cnt <= link_cnt + 1;
            end
            sensor_link_ok <= (link_cnt >= LINK_DLY) ? PRESENT : '0;
        end
    end
endmodule // afm_far_model
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import afm_pkg::*;
;
    localparam int MSC = 10;
    logic mclk, arst_n, cyc, stb, we, wb_ack_o, phase_oc, resid_oc, card_present, net_in;
    logic [5:0] vout;
    logic alarm_relay_output, event_valid, install_ready;
    logic [7:0] adr, stage_active;
    logic [3:0] sel, trip_outputs, breaker_open;
    logic [31:0] wdat, wb_dat_o, rd;
    logic [9:0] light_cmd, light_sensor, sensor_present, sensor_link_ok, phase_threshold, resid_threshold;
    logic [39:0] general_matrix_set;
    logic [4:0] event_code;
    int n_fail, n_checks, n_cyc, n_on, n_off, t;
    afm_top #(.MS_CYC(MSC)) dut_u (
        .mclk(mclk),
        .arst_n(arst_n),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .light_sensor(light_sensor),
        .network_arc_input(net_in),
        .phase_oc(phase_oc),
        .resid_oc(resid_oc),
        .virtual_out(vout),
        .card_present(card_present),
        .sensor_present(sensor_present),
        .sensor_link_ok(sensor_link_ok),
        .trip_outputs(trip_outputs),
        .alarm_relay_output(alarm_relay_output),
        .phase_threshold(phase_threshold),
        .resid_threshold(resid_threshold),
        .general_matrix_set(general_matrix_set),
        .stage_active(stage_active),
        .event_valid(event_valid),
        .event_code(event_code),
        .install_ready(install_ready)
    );
    afm_far_model far_u (
        .mclk(mclk),
        .arst_n(arst_n),
        .light_cmd(light_cmd),
        .install_ready(install_ready),
        .trip_outputs(trip_outputs),
        .light_sensor(light_sensor),
        .sensor_present(sensor_present),
        .sensor_link_ok(sensor_link_ok),
        .breaker_open(breaker_open)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic complete_run();
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        n_cyc++;
        if (n_cyc == 6000) begin
            n_fail++;
            complete_run();
        end
    end
    always @(posedge mclk) begin
        if (event_valid === 1'b1 && event_code === 5'h04) n_on++;
        if (event_valid === 1'b1 && event_code === 5'h14) n_off++;
    end
    task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("ack", 40'h1, {39'h0, n < 50});
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(nm, {8'h00, exp}, {8'h00, rd});
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask
    initial begin
        {n_fail, n_checks, n_cyc, n_on, n_off} = '0;
        {arst_n, cyc, stb, we, phase_oc, resid_oc, card_present, net_in} = '0;
        vout = 6'h00;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        light_cmd = 10'h000;
        wait_cycles(20);
        arst_n <= 1'b1;
        card_present <= 1'b1;
        rdchk("evt_en", ADR_EVT_EN, 32'h0FFF_0FFF);
        rdchk("timing", ADR_TIMING, 32'h0000_0200);
        rdchk("unmapped", 8'hFC, 32'h0000_0000);
        xfer(ADR_PHASE_THR, 1'b1, 32'h0000_00C8);
        xfer(ADR_PHASE_THR, 1'b1, 32'h0000_0031);
        xfer(ADR_RESID_THR, 1'b1, 32'h0000_01F5);
        rdchk("ph_thr", ADR_PHASE_THR, 32'h0000_00C8);
        rdchk("rs_thr", ADR_RESID_THR, 32'h0000_0064);
        card_present <= 1'b0;
        wait_cycles(4);
        xfer(ADR_PHASE_THR, 1'b1, 32'h0000_012C);
        rdchk("no_card", ADR_PHASE_THR, 32'h0000_00C8);
        card_present <= 1'b1;
        xfer(ADR_CTRL, 1'b1, 32'h0000_0200);
        wait_cycles(2);
        chk("installing", 40'h0, install_ready);
        for (t = 0; install_ready !== 1'b1 && t < 300; t++) @(posedge mclk);
        chk("ready", 40'h1, install_ready);
        rdchk("installed", ADR_INSTALLED, 32'h0000_003C);
        xfer(ADR_EVT_EN, 1'b1, 32'h0FFF_0FEF);
        xfer(ADR_LSEL, 1'b1, 32'h0000_0001);
        xfer(ADR_CSEL, 1'b1, 32'h0000_0001);
        xfer(ADR_LSEL + 8'h04, 1'b1, 32'h0000_0002);
        xfer(ADR_TIMING + 8'h04, 1'b1, 32'h0000_0203);
        xfer(ADR_LSEL + 8'h08, 1'b1, 32'h0000_0004);
        xfer(ADR_TRIP_MAP, 1'b1, 32'h0000_0401);
        xfer(ADR_ALARM_MAP, 1'b1, 32'h0000_1002);
        xfer(ADR_CTRL, 1'b1, 32'h0000_0003);
        chk("gen_matrix", 40'h02_0000_0401, general_matrix_set);
        light_cmd <= 10'h005;
        wait_cycles(30);
        chk("light_only", 40'h0, {stage_active, trip_outputs});
        phase_oc <= 1'b1;
        for (t = 0; trip_outputs[0] !== 1'b1 && t < 200; t++) @(posedge mclk);
        chk("trip_time", 40'h1, {39'h0, t <= 9 * MSC});
        chk("trip", 40'h1, trip_outputs);
        rdchk("status", ADR_STATUS, 32'h0003_0101);
        light_cmd <= 10'h000;
        phase_oc <= 1'b0;
        wait_cycles(150);
        chk("hold", 40'h1, trip_outputs);
        wait_cycles(300);
        chk("released", 40'h0, {stage_active, trip_outputs});
        light_cmd <= 10'h002;
        for (t = 0; stage_active[1] !== 1'b1 && t < 200; t++) @(posedge mclk);
        chk("delay", 40'h1, {39'h0, t >= 2 * MSC && t <= 3 * MSC + 8});
        wait_cycles(4);
        chk("alarm", 40'h1, alarm_relay_output);
        light_cmd <= 10'h000;
        wait_cycles(400);
        chk("latched", 40'h1, {stage_active, alarm_relay_output});
        xfer(ADR_CTRL, 1'b1, 32'h0000_0103);
        wait_cycles(3);
        chk("cleared", 40'h0, alarm_relay_output);
        chk("ev_on", 40'h0, n_on);
        chk("ev_off", 40'h1, n_off);
        chk("breaker", 40'h1, breaker_open);
        xfer(ADR_LSEL + 8'h08, 1'b1, 32'h0000_0400);
        xfer(ADR_CSEL + 8'h08, 1'b1, 32'h0000_0008);
        xfer(ADR_CTRL, 1'b1, 32'h0000_0007);
        net_in <= 1'b1;
        wait_cycles(10);
        chk("net_only", 40'h0, stage_active);
        vout <= 6'h01;
        wait_cycles(10);
        chk("net_vout", 40'h042, {stage_active, trip_outputs});
        complete_run();
    end
endmodule // tb
`default_nettype wire
